// ---- common/spr_pkg.sv ----
`default_nettype none
package spr_pkg;
	// ********************************
	// Register map and field layout
	// ********************************
	localparam int ADDR_W = 2;
	localparam logic [1:0] SLEEP_CTRL_ADDR = 2'h0;
	localparam logic [1:0] MCU_CTRL_ADDR = 2'h1;
	localparam logic [1:0] PWR_RED_ADDR = 2'h2;
	localparam int ALLOW_BIT = 0;
	localparam int SM_LSB = 1;
	localparam int UNLOCK_BIT = 5;
	localparam int BOFF_BIT = 6;
	localparam int JTAG_OFF_BIT = 7;
	localparam int LCD_BIT = 4;
	localparam int TIM1_BIT = 3;
	localparam int SPI_BIT = 2;
	localparam int USART_BIT = 1;
	localparam int ADC_BIT = 0;
	localparam logic [3:0] SLEEP_CTRL_RST = 4'h0;
	localparam logic [4:0] PWR_RED_RST = 5'h00;

	// ********************************
	// Sleep mode codes
	// ********************************
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_ADC_NR = 3'h1;
	localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
	localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;

	// ********************************
	// Timing in clock cycles
	// ********************************
	localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
	localparam logic [2:0] BOFF_ACTIVE_CYC = 3'h3;
	localparam logic [2:0] BOFF_HOLD_CYC = 3'h3;
	localparam logic [2:0] STANDBY_WAKE_CYC = 3'h6;
	localparam logic [2:0] OTHER_WAKE_CYC = 3'h2;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WAKE = 2'b11
	} spr_state_e;

	function automatic logic mode_legal(input logic [2:0] m);
		return m inside {MODE_IDLE, MODE_ADC_NR, MODE_PWR_DOWN,
			MODE_PWR_SAVE, MODE_STANDBY};
	endfunction

	function automatic logic [19:0] stretch_cycles(input logic [1:0] stf,
		input logic [3:0] csf, input logic [19:0] base);
		logic [19:0] unit;
		unit = base * 20'({16'h0000, csf} + 20'h00001);
		return unit << stf;
	endfunction
endpackage
`default_nettype wire

// ---- rtl/spr_rst_stretch.sv ----
`default_nettype none
module spr_rst_stretch #(
	parameter logic [19:0] BASE_CYC = 20'h00040
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] startup_time_fuses,
	input wire logic [3:0] clock_select_fuses,
	output logic core_rst
);
	logic loaded_reg;
	logic [19:0] cnt_reg;
	logic [19:0] cnt_next;
	wire logic [19:0] load_val;

	// Fuses are sampled only after release, never under reset
	assign load_val = spr_pkg::stretch_cycles(startup_time_fuses,
		clock_select_fuses, BASE_CYC);
	assign cnt_next = loaded_reg ? cnt_reg - 20'h00001 : load_val;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			loaded_reg <= 1'b0;
			cnt_reg <= 20'h00000;
			core_rst <= 1'b1;
		end else if (core_rst) begin
			loaded_reg <= 1'b1;
			cnt_reg <= cnt_next;
			core_rst <= !(loaded_reg && cnt_reg == 20'h00000);
		end
	end
endmodule
`default_nettype wire

// ---- rtl/spr_power_ctrl.sv ----
// Overview of operation
// - Modes: idle 000, ADC noise 001, down 010, save 011, standby 110.
// - SLEEP enters the selected mode only while sleep_entry_allow is one.
// - Brown-out detector off during sleep if brownout_sleep_off set then.
// - Unlock: write both bits one, then off alone within four cycles.
// - Setting is effective after three cycles, self-clears three later.
// - Only a SLEEP while the setting is effective turns the detector off.
// - The unlock bit is the only way to allow setting brownout_sleep_off.
// - Power reduction bits 7:5 always read zero.
// - lcd_clock_gate shuts the LCD; software disables it first.
// - timer1_clock_gate stops the 16-bit timer; it resumes unchanged.
// - spi_clock_gate stops the SPI clock; software re-initialises after.
// - usart_clock_gate stops the USART clock; software re-inits after.
// - adc_clock_gate shuts the ADC; software disables the ADC first.
// - With the ADC gated the comparator cannot use the ADC input mux.
// - Modes stopping io and ADC clocks disable inputs, not wake inputs.
// - An enabled watchdog keeps running in every sleep mode.
// - With debug fuse, power-down and power-save keep the main clock.
// - jtag_disable_bit or unprogrammed jtag fuse disables JTAG.
// - Reset restores all registers; execution restarts at reset vector.
// - Ports return to initial state at once on reset, clock or not.
// - A fuse-selected delay counter stretches reset after sources end.
// - Standby wake-up resumes six clock cycles after the wake event.
// - A gated peripheral is frozen, inaccessible, restored when ungated.
//
// Added by the designer: strobed register access and the register addresses.
`default_nettype none
module spr_power_ctrl #(
	parameter logic [19:0] STRETCH_BASE_CYC = 20'h00040
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [spr_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic sleep_instr,
	input wire logic wake_event,
	input wire logic bod_fuse_en,
	input wire logic wdt_enable,
	input wire logic debug_enable_fuse,
	input wire logic jtag_enable_fuse,
	input wire logic [1:0] startup_time_fuses,
	input wire logic [3:0] clock_select_fuses,
	output logic cpu_clk_en,
	output logic io_clk_en,
	output logic adc_domain_clk_en,
	output logic main_osc_en,
	output logic bod_enable,
	output logic input_buf_en,
	output logic wake_buf_en,
	output logic wdt_run,
	output logic jtag_en,
	output logic lcd_clk_en,
	output logic tim1_clk_en,
	output logic spi_clk_en,
	output logic usart_clk_en,
	output logic adc_clk_en,
	output logic comp_mux_en,
	output logic [4:0] periph_access_en,
	output logic io_port_init,
	output logic core_rst_out,
	output logic reset_vector_go
);
	default clocking main_cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ********************************
	// Register state
	// ********************************
	logic [3:0] sleep_ctrl_reg;
	logic [4:0] pwr_red_reg;
	logic jtag_off_reg;
	logic boff_reg;
	logic [2:0] boff_age_reg;
	logic [2:0] unlock_cnt_reg;
	logic [2:0] mode_reg;
	logic bod_off_reg;
	logic [2:0] wake_cnt_reg;
	spr_pkg::spr_state_e state_reg;
	spr_pkg::spr_state_e state_next;
	logic core_rst;
	logic core_rst_q;

	spr_rst_stretch #(
		.BASE_CYC(STRETCH_BASE_CYC)
	) u_stretch (
		.clock(clock),
		.rst_n(rst_n),
		.startup_time_fuses(startup_time_fuses),
		.clock_select_fuses(clock_select_fuses),
		.core_rst(core_rst)
	);

	// ********************************
	// Decoding
	// ********************************
	wire logic wr_sleep = wr && addr == spr_pkg::SLEEP_CTRL_ADDR;
	wire logic wr_mcu = wr && addr == spr_pkg::MCU_CTRL_ADDR;
	wire logic wr_pwr = wr && addr == spr_pkg::PWR_RED_ADDR;
	wire logic unlock_open = unlock_cnt_reg != 3'h0;
	wire logic w_boff = wdata[spr_pkg::BOFF_BIT];
	wire logic w_unlock = wdata[spr_pkg::UNLOCK_BIT];
	wire logic unlock_start = wr_mcu && w_boff && w_unlock;
	// Setting is only accepted inside the open window
	wire logic boff_set = wr_mcu && w_boff && !w_unlock && unlock_open;
	wire logic boff_clr = wr_mcu && !w_boff;
	wire logic boff_active = boff_reg && boff_age_reg >= spr_pkg::BOFF_ACTIVE_CYC;
	wire logic boff_expire = boff_reg && boff_age_reg ==
		spr_pkg::BOFF_ACTIVE_CYC + spr_pkg::BOFF_HOLD_CYC - 3'h1;
	wire logic [2:0] sel_mode = sleep_ctrl_reg[3:1];
	wire logic sleep_en = sleep_ctrl_reg[spr_pkg::ALLOW_BIT];
	wire logic run = state_reg == spr_pkg::ST_RUN;
	// Reserved codes are treated like a cleared enable
	wire logic sleep_go = sleep_instr && run && sleep_en &&
		spr_pkg::mode_legal(sel_mode);
	wire logic in_sleep = state_reg == spr_pkg::ST_SLEEP;
	wire logic [2:0] wake_load = mode_reg == spr_pkg::MODE_STANDBY ?
		spr_pkg::STANDBY_WAKE_CYC - 3'h2 : spr_pkg::OTHER_WAKE_CYC - 3'h2;
	wire logic m_idle = mode_reg == spr_pkg::MODE_IDLE;
	wire logic m_adcnr = mode_reg == spr_pkg::MODE_ADC_NR;
	wire logic m_deep = mode_reg == spr_pkg::MODE_PWR_DOWN ||
		mode_reg == spr_pkg::MODE_PWR_SAVE;
	wire logic io_on_next = run || m_idle;
	wire logic adc_on_next = run || m_idle || m_adcnr;
	wire logic osc_on_next = run || state_reg == spr_pkg::ST_WAKE ||
		m_idle || m_adcnr || mode_reg == spr_pkg::MODE_STANDBY ||
		(m_deep && debug_enable_fuse);
	wire logic [4:0] gate_off = ~pwr_red_reg;
	wire logic [7:0] mcu_rd = {jtag_off_reg, boff_reg, unlock_open, 5'h00};
	wire logic [7:0] rd_sel =
		addr == spr_pkg::SLEEP_CTRL_ADDR ? {4'h0, sleep_ctrl_reg} :
		addr == spr_pkg::MCU_CTRL_ADDR ? mcu_rd :
		addr == spr_pkg::PWR_RED_ADDR ? {3'h0, pwr_red_reg} : 8'h00;

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sleep_ctrl_reg <= spr_pkg::SLEEP_CTRL_RST;
			pwr_red_reg <= spr_pkg::PWR_RED_RST;
			jtag_off_reg <= 1'b0;
		end else if (core_rst) begin
			sleep_ctrl_reg <= spr_pkg::SLEEP_CTRL_RST;
			pwr_red_reg <= spr_pkg::PWR_RED_RST;
			jtag_off_reg <= 1'b0;
		end else begin
			if (wr_sleep)
				sleep_ctrl_reg <= wdata[3:0];
			if (wr_pwr)
				pwr_red_reg <= wdata[4:0];
			if (wr_mcu)
				jtag_off_reg <= wdata[spr_pkg::JTAG_OFF_BIT];
		end
	end

	// Unlock window and timed brown-out setting
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			unlock_cnt_reg <= 3'h0;
			boff_reg <= 1'b0;
			boff_age_reg <= 3'h0;
		end else if (core_rst) begin
			unlock_cnt_reg <= 3'h0;
			boff_reg <= 1'b0;
			boff_age_reg <= 3'h0;
		end else begin
			if (unlock_start)
				unlock_cnt_reg <= spr_pkg::UNLOCK_WINDOW_CYC;
			else if (unlock_open)
				unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
			if (boff_set && !boff_reg) begin
				boff_reg <= 1'b1;
				boff_age_reg <= 3'h0;
			end else if (boff_expire || boff_clr) begin
				boff_reg <= 1'b0;
				boff_age_reg <= 3'h0;
			end else if (boff_reg) begin
				boff_age_reg <= boff_age_reg + 3'h1;
			end
		end
	end

	// ********************************
	// Sleep sequencing
	// ********************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			spr_pkg::ST_RUN:
				if (sleep_go)
					state_next = spr_pkg::ST_SLEEP;
			spr_pkg::ST_SLEEP:
				if (wake_event)
					state_next = spr_pkg::ST_WAKE;
			spr_pkg::ST_WAKE:
				if (wake_cnt_reg == 3'h0)
					state_next = spr_pkg::ST_RUN;
			default:
				state_next = spr_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= spr_pkg::ST_RUN;
			mode_reg <= spr_pkg::MODE_IDLE;
			bod_off_reg <= 1'b0;
			wake_cnt_reg <= 3'h0;
		end else if (core_rst) begin
			state_reg <= spr_pkg::ST_RUN;
			mode_reg <= spr_pkg::MODE_IDLE;
			bod_off_reg <= 1'b0;
			wake_cnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			if (sleep_go) begin
				mode_reg <= sel_mode;
				bod_off_reg <= boff_active;
			end else if (run) begin
				bod_off_reg <= 1'b0;
			end
			if (in_sleep && wake_event)
				wake_cnt_reg <= wake_load;
			else if (wake_cnt_reg != 3'h0)
				wake_cnt_reg <= wake_cnt_reg - 3'h1;
		end
	end

	// ********************************
	// Clock, gate and pin outputs
	// ********************************
	// Outputs are one cycle behind the state so that all leave flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cpu_clk_en <= 1'b0;
			io_clk_en <= 1'b0;
			adc_domain_clk_en <= 1'b0;
			main_osc_en <= 1'b1;
			bod_enable <= 1'b0;
			input_buf_en <= 1'b0;
			wake_buf_en <= 1'b0;
			wdt_run <= 1'b0;
			jtag_en <= 1'b0;
			rdata <= 8'h00;
		end else begin
			cpu_clk_en <= run && !core_rst;
			io_clk_en <= io_on_next;
			adc_domain_clk_en <= adc_on_next;
			main_osc_en <= osc_on_next;
			bod_enable <= bod_fuse_en && !(bod_off_reg && !run);
			input_buf_en <= io_on_next || adc_on_next;
			wake_buf_en <= 1'b1;
			wdt_run <= wdt_enable;
			jtag_en <= jtag_enable_fuse && !jtag_off_reg;
			rdata <= rd ? rd_sel : 8'h00;
		end
	end

	// Gated peripherals keep their state because only the clock stops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lcd_clk_en <= 1'b0;
			tim1_clk_en <= 1'b0;
			spi_clk_en <= 1'b0;
			usart_clk_en <= 1'b0;
			adc_clk_en <= 1'b0;
			comp_mux_en <= 1'b0;
			periph_access_en <= 5'h00;
		end else begin
			lcd_clk_en <= gate_off[spr_pkg::LCD_BIT];
			tim1_clk_en <= gate_off[spr_pkg::TIM1_BIT] && io_on_next;
			spi_clk_en <= gate_off[spr_pkg::SPI_BIT] && io_on_next;
			usart_clk_en <= gate_off[spr_pkg::USART_BIT] && io_on_next;
			adc_clk_en <= gate_off[spr_pkg::ADC_BIT] && adc_on_next;
			comp_mux_en <= gate_off[spr_pkg::ADC_BIT];
			periph_access_en <= gate_off;
		end
	end

	// ********************************
	// Reset hold
	// ********************************
	// Ports go to initial state asynchronously, no clock needed
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			io_port_init <= 1'b1;
			core_rst_out <= 1'b1;
			core_rst_q <= 1'b1;
			reset_vector_go <= 1'b0;
		end else begin
			io_port_init <= core_rst;
			core_rst_out <= core_rst;
			core_rst_q <= core_rst;
			reset_vector_go <= core_rst_q && !core_rst;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	a_sleep_entry: assert property (sleep_go |=>
		state_reg == spr_pkg::ST_SLEEP)
		else $error("sleep not entered");
	a_sleep_nop: assert property (sleep_instr && run &&
		!sleep_en && !core_rst |=> run)
		else $error("sleep taken without enable");
	a_unlock_guard: assert property ($rose(boff_reg) |->
		$past(unlock_open))
		else $error("brown-out off set outside window");
	a_boff_timing: assert property ($rose(boff_reg) && !wr_mcu ##1
		!wr_mcu[*5] |-> !$past(boff_active, 3) &&
		$past(boff_active, 2) && boff_active ##1 !boff_reg)
		else $error("brown-out off timing wrong");
	a_bod_off: assert property (sleep_go && boff_active &&
		!core_rst |=> ##1 !bod_enable)
		else $error("detector not switched off");
	a_bod_kept: assert property (sleep_go && !boff_active &&
		!core_rst |=> ##1 bod_enable == $past(bod_fuse_en))
		else $error("detector off without setting");
	a_standby_wake: assert property (in_sleep && wake_event &&
		mode_reg == spr_pkg::MODE_STANDBY && !core_rst |->
		(!run)[*6] ##1 run)
		else $error("standby wake not six cycles");
	a_prr_reserved: assert property ($past(rd) &&
		$past(addr) == spr_pkg::PWR_RED_ADDR |-> rdata[7:5] == 3'h0)
		else $error("reserved bits not zero");
	a_adc_gate: assert property (pwr_red_reg[spr_pkg::ADC_BIT] |=>
		!adc_clk_en && !comp_mux_en)
		else $error("adc gate ignored");
	a_input_bufs: assert property (in_sleep &&
		(m_deep || mode_reg == spr_pkg::MODE_STANDBY) |=>
		!input_buf_en && wake_buf_en)
		else $error("input buffers left on");
	a_ocd_clock: assert property (in_sleep && m_deep |=>
		main_osc_en == $past(debug_enable_fuse))
		else $error("main clock wrong in deep sleep");
	a_jtag_off: assert property (jtag_off_reg ||
		!jtag_enable_fuse |=> !jtag_en)
		else $error("jtag left enabled");
	a_wdt_runs: assert property (wdt_enable && !in_sleep ##1
		in_sleep && $stable(wdt_enable) |=> wdt_run)
		else $error("watchdog stopped in sleep");
	a_reg_reset: assert property (core_rst |=>
		pwr_red_reg == spr_pkg::PWR_RED_RST &&
		sleep_ctrl_reg == spr_pkg::SLEEP_CTRL_RST)
		else $error("registers not reset");

	c_standby_cycle: cover property (sleep_go &&
		sel_mode == spr_pkg::MODE_STANDBY ##[1:40] run);
	c_bod_sleep: cover property (sleep_go && boff_active);
	c_unlock_set: cover property (unlock_start ##[1:4] boff_set);
	c_reset_exit: cover property (reset_vector_go);
endmodule
`default_nettype wire

// ---- tb/spr_power_ctrl_tb_top.sv ----
`default_nettype none
module spr_power_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ********************************
	// Stimulus and design
	// ********************************
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [spr_pkg::ADDR_W-1:0] addr = '0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep_instr = 1'b0;
	logic wake_event = 1'b0;
	logic bod_fuse_en = 1'b1;
	logic wdt_enable = 1'b0;
	logic debug_enable_fuse = 1'b0;
	logic jtag_enable_fuse = 1'b1;
	logic [1:0] startup_time_fuses = 2'h0;
	logic [3:0] clock_select_fuses = 4'h0;
	logic [7:0] rdata;
	logic cpu_clk_en, io_clk_en, adc_domain_clk_en, main_osc_en;
	logic bod_enable, input_buf_en, wake_buf_en, wdt_run, jtag_en;
	logic lcd_clk_en, tim1_clk_en, spi_clk_en, usart_clk_en, adc_clk_en;
	logic comp_mux_en, io_port_init, core_rst_out, reset_vector_go;
	logic [4:0] periph_access_en;
	int failures = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'h00017405;
	logic [7:0] exp_q[$];
	logic rd_d = 1'b0;
	int n0, n1;

	always #25 clock = ~clock;

	// Short stretch base keeps reset counts visible in a few cycles
	spr_power_ctrl #(.STRETCH_BASE_CYC(20'h00001)) spr_power_ctrl_i (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sleep_instr(sleep_instr),
		.wake_event(wake_event), .bod_fuse_en(bod_fuse_en),
		.wdt_enable(wdt_enable), .debug_enable_fuse(debug_enable_fuse),
		.jtag_enable_fuse(jtag_enable_fuse),
		.startup_time_fuses(startup_time_fuses),
		.clock_select_fuses(clock_select_fuses),
		.cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en),
		.adc_domain_clk_en(adc_domain_clk_en), .main_osc_en(main_osc_en),
		.bod_enable(bod_enable), .input_buf_en(input_buf_en),
		.wake_buf_en(wake_buf_en), .wdt_run(wdt_run), .jtag_en(jtag_en),
		.lcd_clk_en(lcd_clk_en), .tim1_clk_en(tim1_clk_en),
		.spi_clk_en(spi_clk_en), .usart_clk_en(usart_clk_en),
		.adc_clk_en(adc_clk_en), .comp_mux_en(comp_mux_en),
		.periph_access_en(periph_access_en), .io_port_init(io_port_init),
		.core_rst_out(core_rst_out), .reset_vector_go(reset_vector_go)
	);

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// Expected read data is queued; the monitor below pops it
	task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock);
		rd <= 1'b0;
	endtask

	task automatic pulse_sleep();
		@(posedge clock);
		sleep_instr <= 1'b1;
		@(posedge clock);
		sleep_instr <= 1'b0;
	endtask

	task automatic pulse_wake();
		@(posedge clock);
		wake_event <= 1'b1;
		@(posedge clock);
		wake_event <= 1'b0;
	endtask

	task automatic do_reset(input logic [1:0] stf, input logic [3:0] cks,
		output int n);
		n = 0;
		@(posedge clock);
		rst_n <= 1'b0;
		startup_time_fuses <= stf;
		clock_select_fuses <= cks;
		#1;
		check(io_port_init, 1'b1);
		repeat (12) @(posedge clock);
		@(negedge clock);
		check(core_rst_out, 1'b1);
		check({main_osc_en, cpu_clk_en}, 2'b10);
		@(posedge clock);
		rst_n <= 1'b1;
		while (core_rst_out !== 1'b0 && n < 100) begin
			@(negedge clock);
			n++;
		end
		// Pulse and port release share the edge that ends core reset
		check(reset_vector_go, 1'b1);
		check(io_port_init, 1'b0);
		@(negedge clock);
		check(reset_vector_go, 1'b0);
	endtask

	always @(posedge clock) rd_d <= rd;

	always @(negedge clock) begin
		if (rd_d === 1'b1) begin
			check(rdata, exp_q.pop_front());
		end
	end

	task automatic bod_case(input logic unl, input int gap, input int late,
		input logic exp);
		wr_reg(spr_pkg::SLEEP_CTRL_ADDR, 8'h01);
		if (unl) wr_reg(spr_pkg::MCU_CTRL_ADDR, 8'h60);
		tick(gap);
		wr_reg(spr_pkg::MCU_CTRL_ADDR, 8'h40);
		tick(late);
		pulse_sleep();
		tick(3);
		@(negedge clock);
		check(cpu_clk_en, 1'b0);
		check(bod_enable, exp);
		pulse_wake();
		tick(10);
		wr_reg(spr_pkg::SLEEP_CTRL_ADDR, 8'h00);
	endtask

	// ********************************
	// Test sequence
	// ********************************
	initial begin
		logic [7:0] v;
		logic [2:0] m;
		logic leg;
		do_reset(2'h0, 4'h0, n0);
		for (int a = 0; a < 4; a++) rd_reg(a[1:0], 8'h00);
		wr_reg(2'h3, 8'hFF);
		rd_reg(spr_pkg::PWR_RED_ADDR, 8'h00);
		$display("test reset_values done");

		repeat (8) begin
			v = 8'(rnd());
			wr_reg(spr_pkg::PWR_RED_ADDR, v);
			rd_reg(spr_pkg::PWR_RED_ADDR, {3'h0, v[4:0]});
			tick(2);
			@(negedge clock);
			check(lcd_clk_en, !v[4]);
			check(tim1_clk_en, !v[3]);
			check(spi_clk_en, !v[2]);
			check(usart_clk_en, !v[1]);
			check({adc_clk_en, comp_mux_en}, {2{~v[0]}});
			check(periph_access_en, {~v[4:0]});
		end
		wr_reg(spr_pkg::PWR_RED_ADDR, 8'h00);
		$display("test clock_gates done");

		wr_reg(spr_pkg::MCU_CTRL_ADDR, 8'h80);
		rd_reg(spr_pkg::MCU_CTRL_ADDR, 8'h80);
		tick(2);
		@(negedge clock);
		check(jtag_en, 1'b0);
		wr_reg(spr_pkg::MCU_CTRL_ADDR, 8'h00);
		tick(2);
		@(negedge clock);
		check(jtag_en, 1'b1);
		@(posedge clock);
		jtag_enable_fuse <= 1'b0;
		tick(3);
		@(negedge clock);
		check(jtag_en, 1'b0);
		@(posedge clock);
		jtag_enable_fuse <= 1'b1;
		$display("test jtag done");

		bod_case(1'b1, 0, 3, 1'b0);
		bod_case(1'b0, 0, 3, 1'b1);
		bod_case(1'b1, 5, 3, 1'b1);
		bod_case(1'b1, 0, 9, 1'b1);
		$display("test brownout_unlock done");

		for (int i = 0; i < 16; i++) begin
			m = i[3:1];
			leg = spr_pkg::mode_legal(m);
			v = 8'(rnd());
			@(posedge clock);
			debug_enable_fuse <= i[0];
			wdt_enable <= v[0];
			wr_reg(spr_pkg::SLEEP_CTRL_ADDR, {4'h0, m, 1'b1});
			pulse_sleep();
			tick(3);
			@(negedge clock);
			check(cpu_clk_en, !leg);
			check(wdt_run, v[0]);
			if (leg) begin
				check(io_clk_en, m == spr_pkg::MODE_IDLE);
				check(adc_domain_clk_en, m <= 3'h1);
				check({input_buf_en, wake_buf_en}, {m <= 3'h1, 1'b1});
				check(main_osc_en, (m == 3'h2 || m == 3'h3) ? i[0] : 1'b1);
				pulse_wake();
				tick(5);
				@(negedge clock);
				check(cpu_clk_en, m != spr_pkg::MODE_STANDBY);
				tick(3);
				@(negedge clock);
				check(cpu_clk_en, 1'b1);
			end
			wr_reg(spr_pkg::SLEEP_CTRL_ADDR, 8'h00);
		end
		wr_reg(spr_pkg::SLEEP_CTRL_ADDR, {4'h0, spr_pkg::MODE_PWR_DOWN, 1'b0});
		pulse_sleep();
		tick(3);
		@(negedge clock);
		check(cpu_clk_en, 1'b1);
		$display("test sleep_modes done");

		wr_reg(spr_pkg::PWR_RED_ADDR, 8'h1F);
		do_reset(2'h1, 4'h1, n1);
		check(8'(n1 - n0), 8'h03);
		for (int a = 0; a < 3; a++) rd_reg(a[1:0], 8'h00);
		tick(3);
		$display("test reset_stretch done");
		summarize();
	end

	initial begin
		tick(6000);
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
